// ==== shd_pkg.sv ====
// constants, states and carriers for the serial clock divider
package shd_pkg;

  // core clock and analog terms of the SCL period
  localparam int SHD_TCORE_NS = 40;
  localparam int SHD_PAD_DELAY_NS = 45;
  localparam int SHD_EXTRA_CYC = 3;

  // divider geometry and reset values
  localparam int SHD_MOD_W = 8;
  localparam int SHD_PRE_W = 3;
  localparam int SHD_PHASE_W = 12;
  localparam logic [SHD_PRE_W-1:0] SHD_PRE_LAST = 3'h7;
  localparam logic [SHD_PRE_W-1:0] SHD_PRE_RST = 3'h0;
  localparam logic [SHD_MOD_W-1:0] SHD_MOD_RST = 8'h00;
  localparam logic [SHD_PHASE_W-1:0] SHD_PHASE_RST = 12'h000;
  localparam int SHD_PRE_SHIFT = 3;
  localparam logic [1:0] SHD_SETTLE_LAST = 2'(SHD_EXTRA_CYC - 2);
  localparam logic [1:0] SHD_SETTLE_RST = 2'h0;

  // gray codes along idle, low, rise, settle, high
  typedef enum logic [2:0] {
    SHD_IDLE = 3'h0,
    SHD_LOW = 3'h1,
    SHD_RISE = 3'h3,
    SHD_SETTLE = 3'h2,
    SHD_HIGH = 3'h6
  } shd_state_t;

  // clock control word as held by the port's control register
  typedef struct packed {
    logic prescalerBypassSelect;
    logic [SHD_MOD_W-1:0] dividerModulus;
  } shd_cfg_t;

  // open-drain SCL drive
  typedef struct packed {
    logic sclOut;
    logic sclOe;
  } shd_pin_t;

endpackage : shd_pkg

// ==== shd_count.sv ====
// reloading terminal counter, used for the prescaler and the modulus
`timescale 1ns/100ps
module shd_count #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // control
  input wire logic run,
  input wire logic tickIn,
  input wire logic [WIDTH-1:0] lastVal,
  // terminal count
  output logic tc
);
  import shd_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } shd_cnt_st_t;

  shd_cnt_st_t st_r;
  shd_cnt_st_t st_nxt;

  assign tc = run && tickIn && (st_r.cnt == lastVal);

  always_comb
  begin
    st_nxt = st_r;
    // a stopped counter restarts from zero so every phase is whole
    if (!run || tc)
      st_nxt.cnt = '0;
    else if (tickIn)
      st_nxt.cnt = WIDTH'(st_r.cnt + 1'b1);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else if (clkEn)
      st_r <= st_nxt;
  end

endmodule : shd_count

// ==== shd_scl_gen.sv ====
// SCL generator for the serial host port as I2C master
`timescale 1ns/100ps
// Summary of operation
// - period is Tc*2*(modulus+1)*(8 or 1)
// - bypass low inserts divide-by-eight prescaler
// - bypass high feeds modulus divider directly
// - modulus 0..ff divides by 1..256
// - SCL period adds three clocks plus rise
module shd_scl_gen (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // control
  input wire logic enable,
  input wire shd_pkg::shd_cfg_t cfg,
  // SCL pin
  input wire logic sclIn,
  output shd_pkg::shd_pin_t scl,
  // status
  output logic busy,
  output logic periodTick
);
  import shd_pkg::*;

  typedef struct packed {
    shd_state_t state;
    logic [1:0] settleCnt;
    shd_pin_t pin;
    logic busy;
    logic periodTick;
  } shd_st_t;

  shd_st_t st_r;
  shd_st_t st_nxt;
  logic run;
  logic preTc;
  logic modTick;
  logic modTc;

  ////////////////////////////////////////////////////////////////////////////
  // divider chain

  assign run = (st_r.state == SHD_LOW) || (st_r.state == SHD_HIGH);

  // fixed divide by eight, always counting while a phase runs
  shd_count #(.WIDTH(SHD_PRE_W)) uPre (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .run(run),
    .tickIn(1'b1),
    .lastVal(SHD_PRE_LAST),
    .tc(preTc)
  );

  // bypass feeds every core clock to the modulus stage
  assign modTick = cfg.prescalerBypassSelect ? 1'b1 : preTc;

  // modulus n ends after n+1 ticks
  shd_count #(.WIDTH(SHD_MOD_W)) uMod (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .run(run),
    .tickIn(modTick),
    .lastVal(cfg.dividerModulus),
    .tc(modTc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // phase sequencer

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.periodTick = 1'b0;
    st_nxt.pin.sclOut = 1'b0;
    case (st_r.state)
      SHD_IDLE:
      begin
        if (enable)
        begin
          st_nxt.state = SHD_LOW;
          st_nxt.pin.sclOe = 1'b1;
          st_nxt.busy = 1'b1;
        end
      end
      SHD_LOW:
      begin
        // low half ends on terminal count, then SCL is released
        if (modTc)
        begin
          st_nxt.state = SHD_RISE;
          st_nxt.pin.sclOe = 1'b0;
        end
      end
      SHD_RISE:
      begin
        // the bus rise time lengthens the period by waiting here
        if (sclIn)
        begin
          st_nxt.state = SHD_SETTLE;
          st_nxt.settleCnt = SHD_SETTLE_RST;
        end
      end
      SHD_SETTLE:
      begin
        // rise wait plus settle make the three added core clocks
        if (st_r.settleCnt == SHD_SETTLE_LAST)
          st_nxt.state = SHD_HIGH;
        else
          st_nxt.settleCnt = 2'(st_r.settleCnt + 1'b1);
      end
      SHD_HIGH:
      begin
        if (modTc)
        begin
          st_nxt.periodTick = 1'b1;
          if (enable)
          begin
            st_nxt.state = SHD_LOW;
            st_nxt.pin.sclOe = 1'b1;
          end
          else
          begin
            // stop only after a whole high phase so SCL ends high
            st_nxt.state = SHD_IDLE;
            st_nxt.busy = 1'b0;
          end
        end
      end
      default:
      begin
        st_nxt.state = SHD_IDLE;
        st_nxt.pin.sclOe = 1'b0;
        st_nxt.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r.state <= SHD_IDLE;
      st_r.settleCnt <= SHD_SETTLE_RST;
      st_r.pin <= '0;
      st_r.busy <= 1'b0;
      st_r.periodTick <= 1'b0;
    end
    else if (clkEn)
      st_r <= st_nxt;
  end

  assign scl = st_r.pin;
  assign busy = st_r.busy;
  assign periodTick = st_r.periodTick;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [SHD_PHASE_W-1:0] phaseCnt;
  logic [SHD_PHASE_W-1:0] halfLen;

  // cycles spent so far in the current low or high phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      phaseCnt <= SHD_PHASE_RST;
    else if (clkEn)
      phaseCnt <= (run && !modTc) ? SHD_PHASE_W'(phaseCnt + 1'b1)
                                  : SHD_PHASE_RST;
  end

  assign halfLen = cfg.prescalerBypassSelect ?
    SHD_PHASE_W'({4'h0, cfg.dividerModulus} + 12'h001) :
    SHD_PHASE_W'(({4'h0, cfg.dividerModulus} + 12'h001) << SHD_PRE_SHIFT);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !clkEn);

  a_low_half_len: assert property (
    (st_r.state == SHD_LOW && modTc) |-> phaseCnt == 12'(halfLen - 1'b1))
    else $error("low phase length differs from programmed half period");

  a_high_half_len: assert property (
    (st_r.state == SHD_HIGH && modTc)
      |-> phaseCnt == 12'(halfLen - 1'b1) ##1 periodTick)
    else $error("high phase length or period tick wrong");

  a_prescale_step: assert property (
    (run && !cfg.prescalerBypassSelect && modTc) |-> phaseCnt[2:0] == 3'h7)
    else $error("prescaled divider ended off an eight-clock boundary");

  a_bypass_ratio: assert property (
    (run && cfg.prescalerBypassSelect && modTc)
      |-> phaseCnt == {4'h0, cfg.dividerModulus})
    else $error("bypassed divider ratio is not modulus plus one");

  // any tick into a zero modulus must end the phase, prescaled or not
  a_modulus_ratio: assert property (
    (run && modTick && cfg.dividerModulus == 8'h00)
      |-> modTc)
    else $error("modulus zero does not divide by one");

  a_rise_extra: assert property (
    (st_r.state == SHD_RISE && sclIn)
      |=> (st_r.state == SHD_SETTLE) [*2] ##1 st_r.state == SHD_HIGH)
    else $error("rise to high phase does not add three clocks");

  a_phase_drive: assert property (
    (st_r.state == SHD_LOW && modTc) |=> !scl.sclOe && !scl.sclOut)
    else $error("SCL not released at end of low phase");

  c_prescaled_period: cover property (
    !cfg.prescalerBypassSelect && periodTick);
  c_bypass_period: cover property (
    cfg.prescalerBypassSelect && periodTick);
  c_stretched_rise: cover property (
    st_r.state == SHD_RISE && !sclIn ##1 st_r.state == SHD_RISE && sclIn);
  c_stop_after_high: cover property (
    st_r.state == SHD_HIGH && modTc && !enable);

endmodule : shd_scl_gen

// ==== shd_bus_model.sv ====
// open-drain SCL wire with pull-up and a slave that may stretch
`timescale 1ns/100ps
module shd_bus_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus
  input wire shd_pkg::shd_pin_t scl,
  input wire logic [3:0] stretch,
  output logic sclIn
);
  import shd_pkg::*;
  logic [3:0] hold_r;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      hold_r <= 4'h0;
    else if (scl.sclOe)
      hold_r <= stretch;
    else if (hold_r != 4'h0)
      hold_r <= hold_r - 4'h1;
  // pull-up wins once nobody pulls low; a slow rise looks like a stretch
  assign sclIn = !(scl.sclOe || hold_r != 4'h0);
endmodule : shd_bus_model

// ==== testbench.sv ====
// self-checking bench for the SCL divider
`timescale 1ns/100ps
module testbench;
  import shd_pkg::*;
  logic clk, rst_n, clkEn, enable, sclIn, busy, periodTick, prevOe;
  logic [3:0] stretch;
  shd_cfg_t cfg, c;
  shd_pin_t scl;
  int error_cnt, checks, perCnt, lowCnt, h, s;
  int expLow[$], expPer[$];
  shd_cfg_t tbl[4] = '{9'h102, 9'h1ff, 9'h000, 9'h0ff};

  shd_scl_gen u_shd_scl_gen (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
    .enable(enable), .cfg(cfg), .sclIn(sclIn), .scl(scl), .busy(busy),
    .periodTick(periodTick));
  shd_bus_model u_shd_bus_model (.clk(clk), .rst_n(rst_n), .scl(scl),
    .stretch(stretch), .sclIn(sclIn));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  // bounded wait for a period tick (1) or for idle (0)
  task automatic wait_for(input bit tick);
    int n;
    for (n = 0; n < 10000; n++)
    begin
      @(negedge clk);
      if (tick ? periodTick === 1'b1 : busy === 1'b0)
        break;
    end
    if (n == 10000)
    begin
      error_cnt++;
      close_out();
    end
  endtask : wait_for

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // low phase is checked as it ends, the full period at its tick
  always @(negedge clk)
    if (rst_n)
    begin
      if (prevOe && !scl.sclOe)
        check(16'(lowCnt), 16'(expLow.pop_front()));
      lowCnt = scl.sclOe ? lowCnt + 1 : 0;
      if (scl.sclOe && !prevOe)
        check(16'(busy), 16'h1);
      if (periodTick === 1'b1)
      begin
        check(16'(perCnt), 16'(expPer.pop_front()));
        check(16'(scl.sclOut), 16'h0);
        perCnt = scl.sclOe ? 1 : 0;
      end
      else if (scl.sclOe && !prevOe)
        perCnt = 1;
      else if (perCnt != 0)
        perCnt++;
      prevOe = scl.sclOe;
    end

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    enable = 1'b0;
    clkEn = 1'b1;
    cfg = '0;
    stretch = 4'h0;
    prevOe = 1'b0;
    error_cnt = 0;
    checks = 0;
    perCnt = 0;
    lowCnt = 0;
    void'($urandom(32'h83f8d023));
    repeat (10) @(posedge clk);
    check(16'({scl.sclOe, busy, periodTick}), 16'h0);
    rst_n <= 1'b1;
    // boundaries first, then random legal settings
    for (int t = 0; t < 8; t++)
    begin
      c = tbl[t % 4];
      if (t >= 4)
      begin
        c.prescalerBypassSelect = 1'($urandom % 2);
        c.dividerModulus = c.prescalerBypassSelect ?
          8'(2 + $urandom % 254) : 8'($urandom % 256);
      end
      s = $urandom % 4;
      h = (c.dividerModulus + 1) * (c.prescalerBypassSelect ? 1 : 8);
      repeat (2)
      begin
        expLow.push_back(h);
        expPer.push_back(2 * h + 3 + s);
      end
      @(posedge clk);
      cfg <= c;
      stretch <= 4'(s);
      enable <= 1'b1;
      // a low clock enable must hold the start request off
      clkEn <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check(16'({scl.sclOe, busy}), 16'h0);
      @(posedge clk);
      clkEn <= 1'b1;
      // dropping enable after the first tick still yields a whole second
      wait_for(1'b1);
      @(posedge clk);
      enable <= 1'b0;
      wait_for(1'b0);
    end
    repeat (4) @(posedge clk);
    // every noted low half and period must have been seen
    check(16'(expLow.size() + expPer.size()), 16'h0);
    close_out();
  end
endmodule : testbench
